// [crs_pkg.sv]
package crs_pkg;
  // ************************************************
  // condition flag layout
  // ************************************************
  localparam int CC_UPPER_PRIO = 5;
  localparam int CC_HALF       = 4;
  localparam int CC_LOWER_PRIO = 3;
  localparam int CC_NEG        = 2;
  localparam int CC_ZERO       = 1;
  localparam int CC_CARRY      = 0;
  localparam logic [7:0] CC_RESET      = 8'hEA;
  localparam logic [7:0] CC_FIXED_ONES = 8'hC0;
  // ************************************************
  // stack pointer, register reset values and frame lengths
  // ************************************************
  localparam logic [7:0]  SP_PAGE      = 8'h01;
  localparam logic [7:0]  SP_LOW_RESET = 8'hFF;
  localparam logic [15:0] SP_RESET     = 16'h01FF;
  localparam logic [7:0]  PC_RESET     = 8'h00;
  localparam logic [7:0]  DATA_RESET   = 8'h00;
  localparam logic [2:0]  IRQ_FRAME    = 3'h5;
  localparam logic [2:0]  CALL_FRAME   = 3'h2;
  // ************************************************
  // context save order, one byte per push
  // ************************************************
  typedef enum logic [2:0] {
    CRS_CTX_PCL,
    CRS_CTX_PCH,
    CRS_CTX_X,
    CRS_CTX_A,
    CRS_CTX_CC,
    CRS_CTX_NONE
  } crs_ctx_t;
  // ************************************************
  // stack pointer operations
  // ************************************************
  typedef enum logic [2:0] {
    CRS_SP_HOLD,
    CRS_SP_PUSH,
    CRS_SP_POP,
    CRS_SP_REINIT,
    CRS_SP_LOAD
  } crs_spop_t;
endpackage

// [crs_stack_ptr.sv]
`timescale 1ns/1ps
module crs_stack_ptr (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  // operation
  input  wire crs_pkg::crs_spop_t op_i,
  input  wire logic [7:0]        load_i,
  // state
  output logic [15:0]            sp_o,
  output logic [15:0]            pop_addr_o
);
  logic [7:0] low_reg;
  logic [7:0] low_next;

  always_comb begin
    low_next = low_reg;
    unique case (op_i)
      crs_pkg::CRS_SP_HOLD:   low_next = low_reg;
      // decrement after write; 8-bit wrap, no overflow flag
      crs_pkg::CRS_SP_PUSH:   low_next = low_reg - 8'h01;
      crs_pkg::CRS_SP_POP:    low_next = low_reg + 8'h01;
      crs_pkg::CRS_SP_REINIT: low_next = crs_pkg::SP_LOW_RESET;
      crs_pkg::CRS_SP_LOAD:   low_next = load_i;
      default:                low_next = low_reg;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      low_reg <= crs_pkg::SP_LOW_RESET;
    end else begin
      low_reg <= low_next;
    end
  end

  // upper byte forced by hardware
  assign sp_o       = {crs_pkg::SP_PAGE, low_reg};
  // pop reads at incremented address
  assign pop_addr_o = {crs_pkg::SP_PAGE, low_reg + 8'h01};

  property p_push_wraps;
    @(posedge clk_i) disable iff (!nrst_i)
      (op_i == crs_pkg::CRS_SP_PUSH && low_reg == 8'h00) |=> low_reg == 8'hFF;
  endproperty
  a_push_wraps: assert property (p_push_wraps) else $error("push did not wrap");
endmodule

// [crs_register_set.sv]
`timescale 1ns/1ps
// How it works
// - one 8-bit accumulator, written on its enable.
// - two 8-bit index registers; prefix selects the second for one instruction.
// - second index register untouched by interrupt entry and return.
// - 16-bit program counter built from separate low and high bytes.
// - flag byte has bits 7,6 one; priority, half, negative, zero, carry fields.
// - add and add-with-carry set half carry from bit3 carry, else clear.
// - negative flag copies result bit 7 on each result.
// - zero flag set when result is zero, else cleared.
// - carry from arithmetic, set/clear instructions, bit test, shift, rotate.
// - priority bits 10=level0, 01=level1, 00=level2, 11=level3 disabled.
// - interrupt entry loads priority from vector priority; instructions may too.
// - flags pushable, poppable, and individually writable.
// - stack pointer names next free byte; decrement after push, increment before pop.
// - stack page forced; reset or reinit sets low byte, giving 0x01FF.
// - stack pointer wraps both ways silently.
// - interrupt pushes low pc byte first; five bytes, call uses two.
// - stack pointer low byte loadable directly, upper byte fixed.
// - interrupt saves pc, first index, accumulator, flags; return restores them.
module crs_register_set (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // data writes from the datapath
  input  wire logic [7:0]  wdata_i,
  input  wire logic        acc_we_i,
  input  wire logic        idx_we_i,
  input  wire logic        prefix_i,
  input  wire logic        pcl_we_i,
  input  wire logic        pch_we_i,
  input  wire logic [15:0] pc_load_i,
  input  wire logic        pc_load_en_i,
  // flag update from alu
  input  wire logic [7:0]  result_i,
  input  wire logic        nz_upd_i,
  input  wire logic        add_i,
  input  wire logic        half_carry_i,
  input  wire logic        carry_upd_i,
  input  wire logic        carry_i,
  input  wire logic        set_carry_instr_i,
  input  wire logic        clear_carry_instr_i,
  input  wire logic        flags_we_i,
  input  wire logic [7:0]  flag_mask_i,
  input  wire logic        prio_we_i,
  input  wire logic [1:0]  prio_i,
  // interrupt entry and return
  input  wire logic        irq_entry_i,
  input  wire logic [1:0]  vector_priority_regs_i,
  input  wire logic        return_from_isr_instr_i,
  input  wire logic        call_i,
  // stack
  input  wire logic        push_i,
  input  wire logic        pop_i,
  input  wire logic [7:0]  pop_data_i,
  input  wire crs_pkg::crs_ctx_t pop_sel_i,
  input  wire logic        stack_pointer_reinit_instr_i,
  input  wire logic        sp_load_i,
  // register outputs
  output logic [7:0]       acc_o,
  output logic [7:0]       idx_x_o,
  output logic [7:0]       idx_y_o,
  output logic [15:0]      pc_o,
  output logic [7:0]       condition_flags_o,
  output logic [1:0]       prio_level_o,
  output logic [15:0]      stack_pointer_o,
  output logic [15:0]      pop_addr_o,
  // stack write port
  output logic             stack_we_o,
  output logic [7:0]       stack_wdata_o,
  output logic             frame_busy_o
);
  logic [7:0] acc_reg, acc_next;
  logic [7:0] x_reg, x_next;
  logic [7:0] y_reg, y_next;
  logic [7:0] pcl_reg, pcl_next;
  logic [7:0] pch_reg, pch_next;
  logic [5:0] cc_reg, cc_next;
  logic [2:0] seq_reg, seq_next;
  logic [2:0] len_reg, len_next;
  // flags as they stood before the priority load, pushed last in the frame
  logic [5:0] cc_save_reg, cc_save_next;
  crs_pkg::crs_spop_t sp_op;
  logic [7:0] cc_full;

  assign cc_full = crs_pkg::CC_FIXED_ONES | {2'b00, cc_reg};

  // ************************************************
  // frame sequencer: irq pushes 5 bytes, call 2
  // ************************************************
  always_comb begin
    seq_next     = seq_reg;
    len_next     = len_reg;
    cc_save_next = cc_save_reg;
    if (seq_reg != 3'h0) begin
      seq_next = seq_reg + 3'h1;
      if (seq_reg == len_reg) begin
        seq_next = 3'h0;
      end
    end else if (irq_entry_i) begin
      seq_next = 3'h1;
      len_next = crs_pkg::IRQ_FRAME;
      // priority is reloaded at entry; return must see the old level
      cc_save_next = cc_reg;
    end else if (call_i) begin
      seq_next = 3'h1;
      len_next = crs_pkg::CALL_FRAME;
    end
  end

  // pcl first, then pch, x, a, flags; y never saved
  always_comb begin
    stack_we_o    = push_i;
    stack_wdata_o = wdata_i;
    if (seq_reg != 3'h0) begin
      stack_we_o = 1'b1;
      unique case (seq_reg)
        3'h1:    stack_wdata_o = pcl_reg;
        3'h2:    stack_wdata_o = pch_reg;
        3'h3:    stack_wdata_o = x_reg;
        3'h4:    stack_wdata_o = acc_reg;
        3'h5:    stack_wdata_o = crs_pkg::CC_FIXED_ONES | {2'b00, cc_save_reg};
        default: stack_wdata_o = 8'h00;
      endcase
    end
  end

  always_comb begin
    if (stack_pointer_reinit_instr_i) sp_op = crs_pkg::CRS_SP_REINIT;
    else if (sp_load_i) sp_op = crs_pkg::CRS_SP_LOAD;
    else if (stack_we_o) sp_op = crs_pkg::CRS_SP_PUSH;
    else if (pop_i) sp_op = crs_pkg::CRS_SP_POP;
    else sp_op = crs_pkg::CRS_SP_HOLD;
  end

  // ************************************************
  // data registers
  // ************************************************
  always_comb begin
    acc_next = acc_reg;
    x_next   = x_reg;
    y_next   = y_reg;
    pcl_next = pcl_reg;
    pch_next = pch_reg;
    if (acc_we_i) acc_next = wdata_i;
    if (idx_we_i && !prefix_i) x_next = wdata_i;
    if (idx_we_i && prefix_i) y_next = wdata_i;
    if (pc_load_en_i) begin
      pcl_next = pc_load_i[7:0];
      pch_next = pc_load_i[15:8];
    end
    if (pcl_we_i) pcl_next = wdata_i;
    if (pch_we_i) pch_next = wdata_i;
    // return pops restore context; y excluded
    if (pop_i) begin
      unique case (pop_sel_i)
        crs_pkg::CRS_CTX_PCL: pcl_next = pop_data_i;
        crs_pkg::CRS_CTX_PCH: pch_next = pop_data_i;
        crs_pkg::CRS_CTX_X:   x_next   = pop_data_i;
        crs_pkg::CRS_CTX_A:   acc_next = pop_data_i;
        default:              ;
      endcase
    end
  end

  // ************************************************
  // condition flags
  // ************************************************
  always_comb begin
    cc_next = cc_reg;
    if (flags_we_i) begin
      cc_next = (cc_reg & ~flag_mask_i[5:0]) | (wdata_i[5:0] & flag_mask_i[5:0]);
    end
    if (nz_upd_i) begin
      cc_next[crs_pkg::CC_NEG]  = result_i[7];
      cc_next[crs_pkg::CC_ZERO] = (result_i == 8'h00);
    end
    if (add_i) cc_next[crs_pkg::CC_HALF] = half_carry_i;
    if (carry_upd_i) cc_next[crs_pkg::CC_CARRY] = carry_i;
    if (set_carry_instr_i) cc_next[crs_pkg::CC_CARRY] = 1'b1;
    if (clear_carry_instr_i) cc_next[crs_pkg::CC_CARRY] = 1'b0;
    if (prio_we_i) begin
      cc_next[crs_pkg::CC_UPPER_PRIO] = prio_i[1];
      cc_next[crs_pkg::CC_LOWER_PRIO] = prio_i[0];
    end
    if (pop_i && pop_sel_i == crs_pkg::CRS_CTX_CC) begin
      cc_next = pop_data_i[5:0];
    end
    if (irq_entry_i && seq_reg == 3'h0) begin
      cc_next[crs_pkg::CC_UPPER_PRIO] = vector_priority_regs_i[1];
      cc_next[crs_pkg::CC_LOWER_PRIO] = vector_priority_regs_i[0];
    end
  end

  // ************************************************
  // registers
  // ************************************************
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      acc_reg <= crs_pkg::DATA_RESET;
      x_reg   <= crs_pkg::DATA_RESET;
      y_reg   <= crs_pkg::DATA_RESET;
      pcl_reg <= crs_pkg::PC_RESET;
      pch_reg <= crs_pkg::PC_RESET;
      cc_reg  <= crs_pkg::CC_RESET[5:0];
      seq_reg <= 3'h0;
      len_reg <= 3'h0;
      cc_save_reg <= crs_pkg::CC_RESET[5:0];
    end else begin
      acc_reg <= acc_next;
      x_reg   <= x_next;
      y_reg   <= y_next;
      pcl_reg <= pcl_next;
      pch_reg <= pch_next;
      cc_reg  <= cc_next;
      seq_reg <= seq_next;
      len_reg <= len_next;
      cc_save_reg <= cc_save_next;
    end
  end

  crs_stack_ptr u_sp (
    .clk_i      (clk_i),
    .nrst_i     (nrst_i),
    .op_i       (sp_op),
    .load_i     (wdata_i),
    .sp_o       (stack_pointer_o),
    .pop_addr_o (pop_addr_o)
  );

  assign acc_o             = acc_reg;
  assign idx_x_o           = x_reg;
  assign idx_y_o           = y_reg;
  assign pc_o              = {pch_reg, pcl_reg};
  assign condition_flags_o = cc_full;
  // level code: 10->0, 01->1, 00->2, 11->3
  assign prio_level_o = {~(cc_reg[crs_pkg::CC_UPPER_PRIO] ^ cc_reg[crs_pkg::CC_LOWER_PRIO]),
                         cc_reg[crs_pkg::CC_LOWER_PRIO]};
  assign frame_busy_o = (seq_reg != 3'h0);

  // ************************************************
  // checks
  // ************************************************
  property p_fixed_ones;
    @(posedge clk_i) disable iff (!nrst_i) condition_flags_o[7:6] == 2'b11;
  endproperty
  a_fixed_ones: assert property (p_fixed_ones) else $error("cc top bits not one");

  property p_neg;
    @(posedge clk_i) disable iff (!nrst_i)
      (nz_upd_i && !pop_i && !flags_we_i) |=> condition_flags_o[2] == $past(result_i[7]);
  endproperty
  a_neg: assert property (p_neg) else $error("negative flag wrong");

  property p_zero;
    @(posedge clk_i) disable iff (!nrst_i)
      (nz_upd_i && !pop_i && !flags_we_i) |=> condition_flags_o[1] == ($past(result_i) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_half;
    @(posedge clk_i) disable iff (!nrst_i)
      (add_i && !pop_i && !flags_we_i) |=> condition_flags_o[4] == $past(half_carry_i);
  endproperty
  a_half: assert property (p_half) else $error("half carry wrong");

  property p_scf;
    @(posedge clk_i) disable iff (!nrst_i)
      (set_carry_instr_i && !clear_carry_instr_i && !pop_i) |=> condition_flags_o[0];
  endproperty
  a_scf: assert property (p_scf) else $error("carry not set");

  property p_irq_prio;
    @(posedge clk_i) disable iff (!nrst_i)
      (irq_entry_i && !frame_busy_o) |=> prio_level_o ==
        {~($past(vector_priority_regs_i[1]) ^ $past(vector_priority_regs_i[0])),
         $past(vector_priority_regs_i[0])};
  endproperty
  a_irq_prio: assert property (p_irq_prio) else $error("irq priority not loaded");

  property p_irq_frame;
    @(posedge clk_i) disable iff (!nrst_i)
      (irq_entry_i && !frame_busy_o) |=> stack_we_o [*5] ##1 !frame_busy_o;
  endproperty
  a_irq_frame: assert property (p_irq_frame) else $error("irq frame not five bytes");

  property p_pcl_first;
    @(posedge clk_i) disable iff (!nrst_i)
      (irq_entry_i && !frame_busy_o) |=> stack_wdata_o == $past(pc_o[7:0]);
  endproperty
  a_pcl_first: assert property (p_pcl_first) else $error("pcl not first");

  property p_cc_saved;
    @(posedge clk_i) disable iff (!nrst_i)
      (irq_entry_i && !frame_busy_o) |=> ##4 stack_wdata_o == $past(condition_flags_o, 5);
  endproperty
  a_cc_saved: assert property (p_cc_saved) else $error("saved flags not pre-entry");

  property p_y_kept;
    @(posedge clk_i) disable iff (!nrst_i) !idx_we_i |=> $stable(idx_y_o);
  endproperty
  a_y_kept: assert property (p_y_kept) else $error("y changed");

  property p_sp_push;
    @(posedge clk_i) disable iff (!nrst_i)
      (stack_we_o && !stack_pointer_reinit_instr_i && !sp_load_i) |=>
        stack_pointer_o[7:0] == $past(stack_pointer_o[7:0]) - 8'h01;
  endproperty
  a_sp_push: assert property (p_sp_push) else $error("sp not decremented");

  property p_sp_page;
    @(posedge clk_i) disable iff (!nrst_i) stack_pointer_o[15:8] == 8'h01;
  endproperty
  a_sp_page: assert property (p_sp_page) else $error("sp page wrong");

  c_irq:  cover property (@(posedge clk_i) irq_entry_i && !frame_busy_o);
  c_call: cover property (@(posedge clk_i) call_i && !frame_busy_o && !irq_entry_i);
  c_wrap: cover property (@(posedge clk_i) pop_i && stack_pointer_o[7:0] == 8'hFF);
  c_ret:  cover property (@(posedge clk_i)
    return_from_isr_instr_i && pop_i && pop_sel_i == crs_pkg::CRS_CTX_CC);
endmodule

// [crs_stack_mem.sv]
`timescale 1ns/1ps
module crs_stack_mem (
  // clock
  input  wire logic        clk_i,
  // write port from the register set
  input  wire logic        we_i,
  input  wire logic [15:0] waddr_i,
  input  wire logic [7:0]  wdata_i,
  // read port for pops
  input  wire logic [15:0] raddr_i,
  output logic [7:0]       rdata_o
);
  logic [7:0] mem [0:255];
  logic [7:0] last_q = 8'h00;
  // off-page reads toggle every cycle so stale data never passes
  always_comb begin
    if (raddr_i[15:8] == crs_pkg::SP_PAGE) begin
      rdata_o = mem[raddr_i[7:0]];
    end else begin
      rdata_o = ~last_q;
    end
  end
  always @(posedge clk_i) begin
    last_q <= rdata_o;
    if (we_i && waddr_i[15:8] == crs_pkg::SP_PAGE) begin
      mem[waddr_i[7:0]] <= wdata_i;
    end
  end
endmodule

// [cpu_register_set_tb.sv]
`timescale 1ns/1ps
module cpu_register_set_tb;
  // ************************************************
  // signals
  // ************************************************
  logic              clk_i = 1'b0;
  logic              nrst_i = 1'b0;
  logic [7:0]        wdata_i, result_i, flag_mask_i, pop_data_i;
  logic              acc_we_i, idx_we_i, prefix_i, pcl_we_i, pch_we_i, pc_load_en_i;
  logic              nz_upd_i, add_i, half_carry_i, carry_upd_i, carry_i, flags_we_i;
  logic              set_carry_instr_i, clear_carry_instr_i, prio_we_i, irq_entry_i;
  logic              return_from_isr_instr_i, call_i, push_i, pop_i, sp_load_i;
  logic              stack_pointer_reinit_instr_i, stack_we_o, frame_busy_o;
  logic [15:0]       pc_load_i, pc_o, stack_pointer_o, pop_addr_o;
  logic [1:0]        prio_i, vector_priority_regs_i, prio_level_o;
  logic [7:0]        acc_o, idx_x_o, idx_y_o, condition_flags_o, stack_wdata_o;
  crs_pkg::crs_ctx_t pop_sel_i;
  int                n_fail = 0;
  int                checks = 0;
  int                cyc = 0;
  localparam logic [1:0] LV [4] = '{2'h2, 2'h1, 2'h0, 2'h3};

  crs_register_set uut (.clk_i(clk_i), .nrst_i(nrst_i), .wdata_i(wdata_i), .acc_we_i(acc_we_i),
    .idx_we_i(idx_we_i), .prefix_i(prefix_i), .pcl_we_i(pcl_we_i), .pch_we_i(pch_we_i),
    .pc_load_i(pc_load_i), .pc_load_en_i(pc_load_en_i), .result_i(result_i), .nz_upd_i(nz_upd_i),
    .add_i(add_i), .half_carry_i(half_carry_i), .carry_upd_i(carry_upd_i), .carry_i(carry_i),
    .set_carry_instr_i(set_carry_instr_i), .clear_carry_instr_i(clear_carry_instr_i),
    .flags_we_i(flags_we_i), .flag_mask_i(flag_mask_i), .prio_we_i(prio_we_i), .prio_i(prio_i),
    .irq_entry_i(irq_entry_i), .vector_priority_regs_i(vector_priority_regs_i),
    .return_from_isr_instr_i(return_from_isr_instr_i), .call_i(call_i), .push_i(push_i),
    .pop_i(pop_i), .pop_data_i(pop_data_i), .pop_sel_i(pop_sel_i), .sp_load_i(sp_load_i),
    .stack_pointer_reinit_instr_i(stack_pointer_reinit_instr_i), .acc_o(acc_o),
    .idx_x_o(idx_x_o), .idx_y_o(idx_y_o), .pc_o(pc_o), .condition_flags_o(condition_flags_o),
    .prio_level_o(prio_level_o), .stack_pointer_o(stack_pointer_o), .pop_addr_o(pop_addr_o),
    .stack_we_o(stack_we_o), .stack_wdata_o(stack_wdata_o), .frame_busy_o(frame_busy_o));
  crs_stack_mem stk (.clk_i(clk_i), .we_i(stack_we_o), .waddr_i(stack_pointer_o),
    .wdata_i(stack_wdata_o), .raddr_i(pop_addr_o), .rdata_o(pop_data_i));

  always #12.5 clk_i = ~clk_i;
  // ************************************************
  // tasks
  // ************************************************
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic clr;
    {acc_we_i, idx_we_i, prefix_i, pcl_we_i, pch_we_i, pc_load_en_i, nz_upd_i, add_i} = '0;
    {half_carry_i, carry_upd_i, carry_i, set_carry_instr_i, clear_carry_instr_i} = '0;
    {flags_we_i, prio_we_i, irq_entry_i, return_from_isr_instr_i, call_i, push_i} = '0;
    {pop_i, stack_pointer_reinit_instr_i, sp_load_i} = '0;
  endtask
  // one request per edge: inputs set at a falling edge, cleared at the next
  task automatic tick;
    @(negedge clk_i);
    clr();
  endtask
  task automatic pop1(input crs_pkg::crs_ctx_t s);
    pop_sel_i = s;
    pop_i = 1'b1;
    return_from_isr_instr_i = 1'b1;
    tick();
  endtask
  task automatic wait_idle;
    int n;
    for (n = 0; n < 20 && frame_busy_o !== 1'b0; n++) begin
      @(negedge clk_i);
    end
    chk("frame end", 16'(n < 20), 16'h0001);
  endtask
  task automatic close_out;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // hang guard, sized well above the roughly forty cycles the run needs
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      close_out();
    end
  end
  // ************************************************
  // sequence
  // ************************************************
  initial begin
    clr();
    {wdata_i, result_i, flag_mask_i, pc_load_i, prio_i, vector_priority_regs_i} = '0;
    pop_sel_i = crs_pkg::CRS_CTX_NONE;
    repeat (2) @(negedge clk_i);
    nrst_i = 1'b1;
    chk("flags rst", condition_flags_o, 16'h00EA);
    chk("sp rst", stack_pointer_o, 16'h01FF);
    wdata_i = 8'h3C; acc_we_i = 1'b1; tick();
    chk("acc", acc_o, 16'h003C);
    wdata_i = 8'h5A; idx_we_i = 1'b1; tick();
    wdata_i = 8'hA5; idx_we_i = 1'b1; prefix_i = 1'b1; tick();
    chk("x", idx_x_o, 16'h005A);
    chk("y", idx_y_o, 16'h00A5);
    pc_load_i = 16'hABCD; pc_load_en_i = 1'b1; tick();
    chk("pc load", pc_o, 16'hABCD);
    wdata_i = 8'h34; pcl_we_i = 1'b1; tick();
    wdata_i = 8'h12; pch_we_i = 1'b1; tick();
    chk("pc bytes", pc_o, 16'h1234);
    result_i = 8'h80; nz_upd_i = 1'b1; tick();
    chk("n set", condition_flags_o, 16'h00EC);
    result_i = 8'h00; nz_upd_i = 1'b1; add_i = 1'b1; half_carry_i = 1'b1; tick();
    chk("z h set", condition_flags_o, 16'h00FA);
    set_carry_instr_i = 1'b1; tick();
    chk("scf", condition_flags_o, 16'h00FB);
    set_carry_instr_i = 1'b1; clear_carry_instr_i = 1'b1; tick();
    chk("rcf", condition_flags_o, 16'h00FA);
    carry_upd_i = 1'b1; carry_i = 1'b1; add_i = 1'b1; tick();
    chk("c h alu", condition_flags_o, 16'h00EB);
    wdata_i = 8'h3E; flags_we_i = 1'b1; flag_mask_i = 8'h01; tick();
    chk("masked", condition_flags_o, 16'h00EA);
    for (int i = 0; i < 4; i++) begin
      prio_i = i[1:0]; prio_we_i = 1'b1; tick();
      chk("prio bits", {condition_flags_o[5], condition_flags_o[3]}, 16'(i));
      chk("prio level", prio_level_o, LV[i]);
    end
    prio_i = 2'h2; prio_we_i = 1'b1; tick();
    wdata_i = 8'h77; push_i = 1'b1; tick();
    chk("sp push", stack_pointer_o, 16'h01FE);
    wdata_i = 8'h00; acc_we_i = 1'b1; tick();
    pop1(crs_pkg::CRS_CTX_A);
    chk("pop a", acc_o, 16'h0077);
    chk("sp pop", stack_pointer_o, 16'h01FF);
    vector_priority_regs_i = 2'h1; irq_entry_i = 1'b1; tick();
    chk("busy", frame_busy_o, 16'h0001);
    chk("irq prio", prio_level_o, 16'h0001);
    call_i = 1'b1; tick();
    wait_idle();
    chk("sp irq", stack_pointer_o, 16'h01FA);
    chk("frame pcl", stk.mem[8'hFF], 16'h0034);
    chk("frame pch", stk.mem[8'hFE], 16'h0012);
    chk("frame x", stk.mem[8'hFD], 16'h005A);
    chk("frame a", stk.mem[8'hFC], 16'h0077);
    chk("frame cc", stk.mem[8'hFB], 16'h00E2);
    chk("y kept", idx_y_o, 16'h00A5);
    wdata_i = 8'h00; acc_we_i = 1'b1; idx_we_i = 1'b1; tick();
    pop1(crs_pkg::CRS_CTX_CC);
    pop1(crs_pkg::CRS_CTX_A);
    pop1(crs_pkg::CRS_CTX_X);
    pop1(crs_pkg::CRS_CTX_PCH);
    pop1(crs_pkg::CRS_CTX_PCL);
    chk("ret prio", prio_level_o, 16'h0000);
    chk("ret a x", {acc_o, idx_x_o}, 16'h775A);
    chk("ret pc", pc_o, 16'h1234);
    chk("ret sp", stack_pointer_o, 16'h01FF);
    call_i = 1'b1; tick();
    wait_idle();
    chk("sp call", stack_pointer_o, 16'h01FD);
    chk("call pc", {stk.mem[8'hFE], stk.mem[8'hFF]}, 16'h1234);
    stack_pointer_reinit_instr_i = 1'b1; tick();
    chk("reinit", stack_pointer_o, 16'h01FF);
    wdata_i = 8'h00; sp_load_i = 1'b1; tick();
    chk("sp load", stack_pointer_o, 16'h0100);
    wdata_i = 8'h9D; push_i = 1'b1; tick();
    chk("wrap down", stack_pointer_o, 16'h01FF);
    chk("wrap data", stk.mem[8'h00], 16'h009D);
    pop1(crs_pkg::CRS_CTX_NONE);
    chk("wrap up", stack_pointer_o, 16'h0100);
    close_out();
  end
endmodule
